// ==== hw/tmr_pkg.sv ====
// tmr_pkg.sv: constants, types and decode functions of the 16-bit capture/compare timer
// Function
// - with filter on, filtered capture input changes after four equal pin samples
// - with filter on, a capture event is seen four clock cycles later
// - edge select zero triggers capture on falling edges, one on rising
// - a capture event copies the counter into capture register and sets flag
// - when capture register is counter top, capture input is disconnected
// - clock select 000 stops, 001..101 give divide by 1, 8, 64, 256, 1024
// - clock select 110 counts external pin falling edges, 111 rising edges
// - force strobes act only in non-PWM wave modes, ignored otherwise
// - a force strobe applies an immediate match per the output mode now set
// - a force strobe sets no flag and never clears the counter
// - force strobe bits always read back as zero
// - 16-bit registers go through one shared 8-bit high-byte holding register
// - a counter write blocks compare matches on the next timer clock
// - capture source is the capture pin or optionally the analog comparator
// - both compare registers are compared continuously with the counter
// - reset clears control B, control C and all counter, capture, compare bytes
// - four-bit wave mode picks count sequence, top source and waveform type
// - compare flag sets in the timer cycle after counter equals compare value
`default_nettype none
package tmr_pkg;
	localparam logic [7:0] OFF_CTRL_B = 8'h81;
	localparam logic [7:0] OFF_CTRL_C = 8'h82;
	localparam logic [7:0] OFF_CNT_L  = 8'h84;
	localparam logic [7:0] OFF_CNT_H  = 8'h85;
	localparam logic [7:0] OFF_CAP_L  = 8'h86;
	localparam logic [7:0] OFF_CAP_H  = 8'h87;
	localparam logic [7:0] OFF_CMPA_L = 8'h88;
	localparam logic [7:0] OFF_CMPA_H = 8'h89;
	localparam logic [7:0] OFF_CMPB_L = 8'h8A;
	localparam logic [7:0] OFF_CMPB_H = 8'h8B;

	localparam int NOISE_BIT   = 7;
	localparam int EDGE_BIT    = 6;
	localparam int WM3_BIT     = 4;
	localparam int WM2_BIT     = 3;
	localparam int CS_MSB      = 2;
	localparam int CS_LSB      = 0;
	localparam int FORCE_A_BIT = 7;
	localparam int FORCE_B_BIT = 6;
	localparam logic [7:0] CTRL_B_WMASK = 8'hDF;
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam int FILT_LEN = 4;

	localparam logic [9:0]  PRE_MASK_8    = 10'h007;
	localparam logic [9:0]  PRE_MASK_64   = 10'h03F;
	localparam logic [9:0]  PRE_MASK_256  = 10'h0FF;
	localparam logic [9:0]  PRE_MASK_1024 = 10'h3FF;
	localparam logic [15:0] TOP_8   = 16'h00FF;
	localparam logic [15:0] TOP_9   = 16'h01FF;
	localparam logic [15:0] TOP_10  = 16'h03FF;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;

	localparam logic [3:0] WM_NORMAL    = 4'h0;
	localparam logic [3:0] WM_PC_8      = 4'h1;
	localparam logic [3:0] WM_PC_9      = 4'h2;
	localparam logic [3:0] WM_PC_10     = 4'h3;
	localparam logic [3:0] WM_CTC_OCRA  = 4'h4;
	localparam logic [3:0] WM_FAST_8    = 4'h5;
	localparam logic [3:0] WM_FAST_9    = 4'h6;
	localparam logic [3:0] WM_FAST_10   = 4'h7;
	localparam logic [3:0] WM_PFC_ICR   = 4'h8;
	localparam logic [3:0] WM_PFC_OCRA  = 4'h9;
	localparam logic [3:0] WM_PC_ICR    = 4'hA;
	localparam logic [3:0] WM_PC_OCRA   = 4'hB;
	localparam logic [3:0] WM_CTC_ICR   = 4'hC;
	localparam logic [3:0] WM_FAST_ICR  = 4'hE;
	localparam logic [3:0] WM_FAST_OCRA = 4'hF;

	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	typedef enum logic [2:0] {
		CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
	} tmr_clk_sel_t;

	typedef enum logic [1:0] {
		DIR_UP   = 2'b01,
		DIR_DOWN = 2'b10
	} tmr_dir_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmr_bus_t;

	typedef struct packed {
		logic [7:0]  ctrl_b;
		logic [7:0]  temp;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [9:0]  pre;
		logic        ext_prev;
		logic        cap_prev;
		logic        blk;
		logic [1:0]  match;
		logic        cap_flag;
		logic [1:0]  cmp_flag;
		logic [1:0]  oc;
		tmr_dir_t    dir;
		logic [7:0]  rdata;
	} tmr_state_t;

	function automatic logic is_pwm(input logic [3:0] wm);
		return !(wm == WM_NORMAL || wm == WM_CTC_OCRA || wm == WM_CTC_ICR);
	endfunction : is_pwm

	function automatic logic is_dual_slope(input logic [3:0] wm);
		return wm inside {WM_PC_8, WM_PC_9, WM_PC_10, WM_PFC_ICR, WM_PFC_OCRA, WM_PC_ICR, WM_PC_OCRA};
	endfunction : is_dual_slope

	function automatic logic icr_is_top(input logic [3:0] wm);
		return wm inside {WM_PFC_ICR, WM_PC_ICR, WM_CTC_ICR, WM_FAST_ICR};
	endfunction : icr_is_top

	function automatic logic [15:0] top_of(input logic [3:0] wm, input logic [15:0] ocra, input logic [15:0] icr);
		logic [15:0] t;
		t = TOP_MAX;
		if (wm inside {WM_PC_8, WM_FAST_8}) t = TOP_8;
		else if (wm inside {WM_PC_9, WM_FAST_9}) t = TOP_9;
		else if (wm inside {WM_PC_10, WM_FAST_10}) t = TOP_10;
		else if (wm inside {WM_CTC_OCRA, WM_PFC_OCRA, WM_PC_OCRA, WM_FAST_OCRA}) t = ocra;
		else if (icr_is_top(wm)) t = icr;
		return t;
	endfunction : top_of

	// new waveform level on a compare match, real or forced
	function automatic logic oc_on_match(input logic oc, input logic [1:0] com, input logic [3:0] wm,
		input logic up, input logic is_a);
		logic r;
		r = oc;
		unique case (com)
			COM_OFF: r = oc;
			COM_TOGGLE: begin
				if (!is_pwm(wm) || (is_a && wm inside {WM_PFC_OCRA, WM_PC_OCRA, WM_FAST_OCRA, WM_FAST_ICR})) r = !oc;
			end
			COM_CLEAR: r = is_dual_slope(wm) ? !up : 1'b0;
			COM_SET:   r = is_dual_slope(wm) ? up : 1'b1;
		endcase
		return r;
	endfunction : oc_on_match

	function automatic logic oc_at_bottom(input logic oc, input logic [1:0] com);
		return (com == COM_CLEAR) ? 1'b1 : (com == COM_SET) ? 1'b0 : oc;
	endfunction : oc_at_bottom

	function automatic logic clk_tick(input tmr_clk_sel_t cs, input logic [9:0] pre, input logic fall,
		input logic rise);
		logic t;
		unique case (cs)
			CS_STOP:     t = 1'b0;
			CS_DIV1:     t = 1'b1;
			CS_DIV8:     t = (pre & PRE_MASK_8) == PRE_MASK_8;
			CS_DIV64:    t = (pre & PRE_MASK_64) == PRE_MASK_64;
			CS_DIV256:   t = (pre & PRE_MASK_256) == PRE_MASK_256;
			CS_DIV1024:  t = (pre & PRE_MASK_1024) == PRE_MASK_1024;
			CS_EXT_FALL: t = fall;
			CS_EXT_RISE: t = rise;
		endcase
		return t;
	endfunction : clk_tick
endpackage : tmr_pkg
`default_nettype wire

// ==== hw/tmr_cap_filter.sv ====
// tmr_cap_filter.sv: capture input noise filter with an unfiltered bypass
`default_nettype none
module tmr_cap_filter #(
	parameter int FILT_LEN = 4
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// capture source and filter control
	input  wire logic pin_i,
	input  wire logic en_i,
	// selected capture level
	output logic      level_o
);
	typedef struct packed {
		logic [FILT_LEN-1:0] sh;
		logic                filt;
		logic                raw;
	} tmr_filt_state_t;

	if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_len_chk
		$error("filter length must be 2 to 16");
	end

	tmr_filt_state_t st_ff;
	tmr_filt_state_t nxt_st;

	always_comb begin
		nxt_st     = st_ff;
		nxt_st.raw = pin_i;
		nxt_st.sh  = {st_ff.sh[FILT_LEN-2:0], pin_i};
		if (&st_ff.sh) begin
			nxt_st.filt = 1'b1;
		end else if (~|st_ff.sh) begin
			nxt_st.filt = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// both paths register the pin once, so the filter adds exactly FILT_LEN cycles
	assign level_o = en_i ? st_ff.filt : st_ff.raw;

	AST_FILT_NEEDS_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(st_ff.filt != $past(st_ff.filt)) |-> ($past(st_ff.sh) == {FILT_LEN{st_ff.filt}}))
		else $error("filter output changed without a full run of equal samples");
	AST_FILT_LAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		($rose(st_ff.raw) && !st_ff.filt && en_i) ##1 (st_ff.raw && en_i) [*3] |=> $rose(st_ff.filt))
		else $error("filtered capture level not four cycles behind raw level");
	COV_FILT_RISE: cover property (@(posedge clk_i) disable iff (!rst_n_i) en_i && $rose(st_ff.filt));
endmodule : tmr_cap_filter
`default_nettype wire

// ==== hw/tmr_top.sv ====
// tmr_top.sv: 16-bit timer with input capture, two compare channels and byte register port
`default_nettype none
module tmr_top (
	// clock and reset
	input  wire logic              CORE_CLK_I,
	input  wire logic              RST_N_I,
	// register port
	input  wire tmr_pkg::tmr_bus_t REG_BUS_I,
	output logic [7:0]             RDATA_O,
	// control bits kept outside this register group
	input  wire logic [1:0]        WAVE_MODE_LO_I,
	input  wire logic [1:0]        COMPARE_A_MODE_I,
	input  wire logic [1:0]        COMPARE_B_MODE_I,
	input  wire logic              CAPTURE_SRC_ANALOG_I,
	// pins
	input  wire logic              CAPTURE_PIN_I,
	input  wire logic              ANALOG_CMP_I,
	input  wire logic              EXTERNAL_COUNT_PIN_I,
	output logic                   COMPARE_A_OUTPUT_O,
	output logic                   COMPARE_A_OUTPUT_EN_O,
	output logic                   COMPARE_B_OUTPUT_O,
	output logic                   COMPARE_B_OUTPUT_EN_O,
	// event flags, clear is write-one style from outside
	input  wire logic [2:0]        FLAG_CLEAR_I,
	output logic                   CAPTURE_FLAG_O,
	output logic                   COMPARE_A_FLAG_O,
	output logic                   COMPARE_B_FLAG_O
);
	tmr_pkg::tmr_state_t   st_ff;
	tmr_pkg::tmr_state_t   nxt_st;
	tmr_pkg::tmr_clk_sel_t clk_sel;
	logic [3:0]            wave_mode;
	logic [15:0]           top_val;
	logic                  pwm;
	logic                  dual;
	logic                  icr_top;
	logic                  tick;
	logic                  cap_raw;
	logic                  cap_level;
	logic                  cap_evt;
	logic                  wr_c;
	logic                  wr_cnt_l;
	logic                  force_a;
	logic                  force_b;
	logic                  up;

	assign wave_mode = {st_ff.ctrl_b[tmr_pkg::WM3_BIT], st_ff.ctrl_b[tmr_pkg::WM2_BIT], WAVE_MODE_LO_I};
	assign clk_sel   = tmr_pkg::tmr_clk_sel_t'(st_ff.ctrl_b[tmr_pkg::CS_MSB:tmr_pkg::CS_LSB]);
	assign top_val   = tmr_pkg::top_of(wave_mode, st_ff.cmp_a, st_ff.cap);
	assign pwm       = tmr_pkg::is_pwm(wave_mode);
	assign dual      = tmr_pkg::is_dual_slope(wave_mode);
	assign icr_top   = tmr_pkg::icr_is_top(wave_mode);
	assign up        = (st_ff.dir == tmr_pkg::DIR_UP);
	assign tick      = tmr_pkg::clk_tick(clk_sel, st_ff.pre, st_ff.ext_prev && !EXTERNAL_COUNT_PIN_I,
		!st_ff.ext_prev && EXTERNAL_COUNT_PIN_I);
	assign cap_raw   = CAPTURE_SRC_ANALOG_I ? ANALOG_CMP_I : CAPTURE_PIN_I;

	tmr_cap_filter #(
		.FILT_LEN (tmr_pkg::FILT_LEN)
	) u_cap_filter (
		.clk_i   (CORE_CLK_I),
		.rst_n_i (RST_N_I),
		.pin_i   (cap_raw),
		.en_i    (st_ff.ctrl_b[tmr_pkg::NOISE_BIT]),
		.level_o (cap_level)
	);

	// capture pin is ignored entirely while the capture register sets the top
	assign cap_evt = !icr_top && (st_ff.ctrl_b[tmr_pkg::EDGE_BIT] ? (cap_level && !st_ff.cap_prev)
		: (!cap_level && st_ff.cap_prev));
	assign wr_c     = REG_BUS_I.wr && REG_BUS_I.addr == tmr_pkg::OFF_CTRL_C;
	assign wr_cnt_l = REG_BUS_I.wr && REG_BUS_I.addr == tmr_pkg::OFF_CNT_L;
	assign force_a  = wr_c && REG_BUS_I.wdata[tmr_pkg::FORCE_A_BIT] && !pwm;
	assign force_b  = wr_c && REG_BUS_I.wdata[tmr_pkg::FORCE_B_BIT] && !pwm;

	always_comb begin
		nxt_st          = st_ff;
		nxt_st.pre      = st_ff.pre + 10'h001;
		nxt_st.ext_prev = EXTERNAL_COUNT_PIN_I;
		nxt_st.cap_prev = cap_level;
		if (tick) begin
			nxt_st.blk = 1'b0;
		end
		// match is registered, so flags and outputs act one cycle after equality
		nxt_st.match[0] = tick && !st_ff.blk && st_ff.cnt == st_ff.cmp_a;
		nxt_st.match[1] = tick && !st_ff.blk && st_ff.cnt == st_ff.cmp_b;
		if (!dual) begin
			nxt_st.dir = tmr_pkg::DIR_UP;
		end
		if (tick) begin
			if (dual) begin
				unique case (st_ff.dir)
					tmr_pkg::DIR_UP: begin
						if (st_ff.cnt >= top_val) begin
							nxt_st.dir = tmr_pkg::DIR_DOWN;
							nxt_st.cnt = st_ff.cnt - 16'h0001;
						end else begin
							nxt_st.cnt = st_ff.cnt + 16'h0001;
						end
					end
					tmr_pkg::DIR_DOWN: begin
						if (st_ff.cnt == 16'h0000) begin
							nxt_st.dir = tmr_pkg::DIR_UP;
							nxt_st.cnt = st_ff.cnt + 16'h0001;
						end else begin
							nxt_st.cnt = st_ff.cnt - 16'h0001;
						end
					end
				endcase
			end else if (st_ff.cnt == top_val) begin
				nxt_st.cnt = 16'h0000;
				if (pwm) begin
					nxt_st.oc[0] = tmr_pkg::oc_at_bottom(st_ff.oc[0], COMPARE_A_MODE_I);
					nxt_st.oc[1] = tmr_pkg::oc_at_bottom(st_ff.oc[1], COMPARE_B_MODE_I);
				end
			end else begin
				nxt_st.cnt = st_ff.cnt + 16'h0001;
			end
		end
		if (st_ff.match[0]) begin
			nxt_st.oc[0] = tmr_pkg::oc_on_match(st_ff.oc[0], COMPARE_A_MODE_I, wave_mode, up, 1'b1);
		end
		if (st_ff.match[1]) begin
			nxt_st.oc[1] = tmr_pkg::oc_on_match(st_ff.oc[1], COMPARE_B_MODE_I, wave_mode, up, 1'b0);
		end
		// forced match touches only the waveform: no flag, no counter clear
		if (force_a) begin
			nxt_st.oc[0] = tmr_pkg::oc_on_match(st_ff.oc[0], COMPARE_A_MODE_I, wave_mode, 1'b1, 1'b1);
		end
		if (force_b) begin
			nxt_st.oc[1] = tmr_pkg::oc_on_match(st_ff.oc[1], COMPARE_B_MODE_I, wave_mode, 1'b1, 1'b0);
		end
		// set wins over a clear in the same cycle
		nxt_st.cap_flag    = (st_ff.cap_flag && !FLAG_CLEAR_I[0]) || cap_evt
			|| (icr_top && tick && st_ff.cnt == top_val);
		nxt_st.cmp_flag[0] = (st_ff.cmp_flag[0] && !FLAG_CLEAR_I[1]) || st_ff.match[0];
		nxt_st.cmp_flag[1] = (st_ff.cmp_flag[1] && !FLAG_CLEAR_I[2]) || st_ff.match[1];
		if (REG_BUS_I.wr) begin
			case (REG_BUS_I.addr)
				tmr_pkg::OFF_CTRL_B: nxt_st.ctrl_b = REG_BUS_I.wdata & tmr_pkg::CTRL_B_WMASK;
				tmr_pkg::OFF_CNT_H, tmr_pkg::OFF_CAP_H, tmr_pkg::OFF_CMPA_H, tmr_pkg::OFF_CMPB_H: begin
					nxt_st.temp = REG_BUS_I.wdata;
				end
				tmr_pkg::OFF_CNT_L: begin
					// a running counter written here may skip a match the software expected
					nxt_st.cnt = {st_ff.temp, REG_BUS_I.wdata};
					nxt_st.blk = 1'b1;
				end
				tmr_pkg::OFF_CAP_L:  nxt_st.cap   = {st_ff.temp, REG_BUS_I.wdata};
				tmr_pkg::OFF_CMPA_L: nxt_st.cmp_a = {st_ff.temp, REG_BUS_I.wdata};
				tmr_pkg::OFF_CMPB_L: nxt_st.cmp_b = {st_ff.temp, REG_BUS_I.wdata};
				default: ;
			endcase
		end
		if (cap_evt) begin
			nxt_st.cap = st_ff.cnt;
		end
		if (REG_BUS_I.rd) begin
			case (REG_BUS_I.addr)
				tmr_pkg::OFF_CTRL_B: nxt_st.rdata = st_ff.ctrl_b;
				tmr_pkg::OFF_CTRL_C: nxt_st.rdata = tmr_pkg::RST_BYTE;
				tmr_pkg::OFF_CNT_L: begin
					nxt_st.rdata = st_ff.cnt[7:0];
					nxt_st.temp  = st_ff.cnt[15:8];
				end
				tmr_pkg::OFF_CAP_L: begin
					nxt_st.rdata = st_ff.cap[7:0];
					nxt_st.temp  = st_ff.cap[15:8];
				end
				tmr_pkg::OFF_CMPA_L: begin
					nxt_st.rdata = st_ff.cmp_a[7:0];
					nxt_st.temp  = st_ff.cmp_a[15:8];
				end
				tmr_pkg::OFF_CMPB_L: begin
					nxt_st.rdata = st_ff.cmp_b[7:0];
					nxt_st.temp  = st_ff.cmp_b[15:8];
				end
				tmr_pkg::OFF_CNT_H, tmr_pkg::OFF_CAP_H, tmr_pkg::OFF_CMPA_H, tmr_pkg::OFF_CMPB_H: begin
					nxt_st.rdata = st_ff.temp;
				end
				default: nxt_st.rdata = tmr_pkg::RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_ff     <= '0;
			st_ff.dir <= tmr_pkg::DIR_UP;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign RDATA_O               = st_ff.rdata;
	assign COMPARE_A_OUTPUT_O    = st_ff.oc[0];
	assign COMPARE_B_OUTPUT_O    = st_ff.oc[1];
	assign COMPARE_A_OUTPUT_EN_O = COMPARE_A_MODE_I != tmr_pkg::COM_OFF;
	assign COMPARE_B_OUTPUT_EN_O = COMPARE_B_MODE_I != tmr_pkg::COM_OFF;
	assign CAPTURE_FLAG_O        = st_ff.cap_flag;
	assign COMPARE_A_FLAG_O      = st_ff.cmp_flag[0];
	assign COMPARE_B_FLAG_O      = st_ff.cmp_flag[1];

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	AST_CAPTURE_COPIES: assert property (cap_evt |=> (st_ff.cap == $past(st_ff.cnt)) && st_ff.cap_flag)
		else $error("capture event did not load counter and set flag");
	AST_CAPTURE_EDGE: assert property ((st_ff.ctrl_b[tmr_pkg::EDGE_BIT] && $fell(cap_level)) |-> !cap_evt)
		else $error("falling edge captured while rising edge selected");
	AST_ICR_TOP_NO_CAPTURE: assert property ((icr_top && cap_level != st_ff.cap_prev
		&& !(REG_BUS_I.wr && REG_BUS_I.addr == tmr_pkg::OFF_CAP_L)) |=> $stable(st_ff.cap))
		else $error("capture register loaded while it is the counter top");
	AST_STOPPED_HOLDS: assert property ((clk_sel == tmr_pkg::CS_STOP && !wr_cnt_l) |=> $stable(st_ff.cnt))
		else $error("counter moved with no clock source");
	AST_FORCE_PWM_IGNORED: assert property ((wr_c && pwm && !tick && st_ff.match == 2'b00) |=> $stable(st_ff.oc))
		else $error("force strobe acted in a PWM mode");
	AST_FORCE_SET: assert property ((force_a && COMPARE_A_MODE_I == tmr_pkg::COM_SET) |=> st_ff.oc[0])
		else $error("forced match did not set output A");
	AST_FORCE_NO_FLAG: assert property ((force_a && !st_ff.match[0] && !st_ff.cmp_flag[0]) |=> !st_ff.cmp_flag[0])
		else $error("forced match set the compare flag");
	AST_FORCE_READS_ZERO: assert property ((REG_BUS_I.rd && REG_BUS_I.addr == tmr_pkg::OFF_CTRL_C)
		|=> RDATA_O == tmr_pkg::RST_BYTE)
		else $error("force strobe bits read back nonzero");
	AST_PAIRED_WRITE: assert property ((REG_BUS_I.wr && REG_BUS_I.addr == tmr_pkg::OFF_CNT_H) ##1 wr_cnt_l
		|=> st_ff.cnt == {$past(REG_BUS_I.wdata, 2), $past(REG_BUS_I.wdata)})
		else $error("counter byte pair not written atomically");
	AST_WRITE_BLOCKS_MATCH: assert property (wr_cnt_l ##1 tick |=> st_ff.match == 2'b00)
		else $error("compare match not blocked after counter write");
	AST_MATCH_FLAG: assert property ((tick && !st_ff.blk && st_ff.cnt == st_ff.cmp_a)
		|=> st_ff.match[0] ##1 st_ff.cmp_flag[0])
		else $error("compare A flag not set the cycle after the match");

	COV_CAPTURE: cover property (cap_evt);
	COV_FORCE_A: cover property (force_a ##1 $changed(st_ff.oc[0]));
	COV_TURN_DOWN: cover property (dual && $rose(st_ff.dir == tmr_pkg::DIR_DOWN));
endmodule : tmr_top
`default_nettype wire

// ==== verification/tmr_cpu_model.sv ====
// tmr_cpu_model.sv: processor-side byte access model for the timer register port
`default_nettype none
module tmr_cpu_model (
	// clock
	input  wire logic         clk_i,
	// register port and read data
	output tmr_pkg::tmr_bus_t bus_o,
	input  wire logic [7:0]   rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;
	initial bus_o = '0;
	// one-cycle strobe, taken at the edge after it is raised
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		bus_o <= '0;
	endtask : wr8
	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		bus_o <= '0;
		#1 d = rdata_i;
	endtask : rd8
	// shared holding byte: pair order matters
	task automatic wr16(input logic [7:0] lo_addr, input logic [15:0] v);
		@(posedge clk_i);
		bus_o <= '{wr: 1'b1, rd: 1'b0, addr: lo_addr + 8'h01, wdata: v[15:8]};
		// low byte follows with no gap, strobe held high across the edge
		@(posedge clk_i);
		bus_o <= '{wr: 1'b1, rd: 1'b0, addr: lo_addr, wdata: v[7:0]};
		@(posedge clk_i);
		bus_o <= '0;
	endtask : wr16
	task automatic rd16(input logic [7:0] lo_addr, output logic [15:0] v);
		rd8(lo_addr, v[7:0]);
		rd8(lo_addr + 8'h01, v[15:8]);
	endtask : rd16
endmodule : tmr_cpu_model
`default_nettype wire

// ==== verification/tmr_top_tb_top.sv ====
// tmr_top_tb_top.sv: self-checking bench for the 16-bit capture/compare timer
`default_nettype none
module tmr_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk     = 1'b0;
	logic              rst_n   = 1'b0;
	logic [1:0]        wm_lo   = 2'h0;
	logic [1:0]        com_a   = 2'h0;
	logic [1:0]        com_b   = 2'h0;
	logic              src_an  = 1'b0;
	logic              cap_pin = 1'b0;
	logic              an_cmp  = 1'b0;
	logic              ext_pin = 1'b0;
	logic [2:0]        fclr    = 3'h0;
	logic [7:0]        lfsr    = 8'h5A;
	tmr_pkg::tmr_bus_t bus;
	logic [7:0]        rdata;
	logic [7:0]        rd_v;
	logic              oc_a, oc_a_en, oc_b, oc_b_en, f_cap, f_a, f_b, ov;
	int                err_count   = 0;
	int                check_count = 0;
	int                cycles      = 0;
	int                mdl [4];
	int                divs [6] = '{1, 1, 8, 64, 256, 1024};
	int                d0, d1;
	always #25 clk = ~clk;
	tmr_top i_tmr_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_BUS_I(bus), .RDATA_O(rdata),
		.WAVE_MODE_LO_I(wm_lo), .COMPARE_A_MODE_I(com_a), .COMPARE_B_MODE_I(com_b),
		.CAPTURE_SRC_ANALOG_I(src_an), .CAPTURE_PIN_I(cap_pin), .ANALOG_CMP_I(an_cmp),
		.EXTERNAL_COUNT_PIN_I(ext_pin), .COMPARE_A_OUTPUT_O(oc_a), .COMPARE_A_OUTPUT_EN_O(oc_a_en),
		.COMPARE_B_OUTPUT_O(oc_b), .COMPARE_B_OUTPUT_EN_O(oc_b_en), .FLAG_CLEAR_I(fclr),
		.CAPTURE_FLAG_O(f_cap), .COMPARE_A_FLAG_O(f_a), .COMPARE_B_FLAG_O(f_b));
	tmr_cpu_model i_tmr_cpu_model (.clk_i(clk), .bus_o(bus), .rdata_i(rdata));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next
	function automatic logic [15:0] rnd16();
		logic [7:0] h;
		lfsr = lfsr_next(lfsr);
		h = lfsr;
		lfsr = lfsr_next(lfsr);
		return {h, lfsr};
	endfunction : rnd16
	task automatic ctrl(input logic [7:0] b);
		i_tmr_cpu_model.wr8(tmr_pkg::OFF_CTRL_B, b);
	endtask : ctrl
	task automatic w16(input int i, input logic [15:0] v);
		i_tmr_cpu_model.wr16(tmr_pkg::OFF_CNT_L + 8'(2 * i), v);
		mdl[i] = int'(v);
	endtask : w16
	task automatic r16(input int i);
		logic [15:0] v;
		i_tmr_cpu_model.rd16(tmr_pkg::OFF_CNT_L + 8'(2 * i), v);
		chk(v, 16'(mdl[i]), "16-bit register");
	endtask : r16
	task automatic clr;
		@(posedge clk) fclr <= 3'h7;
		@(posedge clk) fclr <= 3'h0;
	endtask : clr
	// edges until a flag rises, bounded
	task automatic wait_flag(input int which, output int n);
		n = 0;
		while ((which == 0 ? f_cap : which == 1 ? f_a : f_b) !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_flag
	// counter is stopped, so the captured value is known
	task automatic cap_step(input logic [7:0] cb, input logic lvl, input logic yes, output int d);
		ctrl(cb);
		w16(0, rnd16());
		@(posedge clk);
		if (src_an) an_cmp <= lvl;
		else cap_pin <= lvl;
		wait_flag(0, d);
		chk(16'(f_cap), 16'(yes), "capture flag");
		if (yes) mdl[1] = mdl[0];
		r16(1);
		clr();
	endtask : cap_step
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 8'h81; a <= 8'h8B; a++) begin
			i_tmr_cpu_model.rd8(8'(a), rd_v);
			chk(16'(rd_v), 16'h0000, "reset or unmapped byte");
		end
		chk(16'({oc_a_en, oc_b_en}), 16'h0000, "output enables off");
		$display("test reset done");
		for (int i = 0; i < 4; i++) w16(i, rnd16());
		for (int i = 0; i < 4; i++) r16(i);
		ctrl(8'hF8);
		i_tmr_cpu_model.rd8(tmr_pkg::OFF_CTRL_B, rd_v);
		chk(16'(rd_v), 16'h00D8, "control B readback");
		i_tmr_cpu_model.wr8(tmr_pkg::OFF_CTRL_C, 8'hC0);
		i_tmr_cpu_model.rd8(tmr_pkg::OFF_CTRL_C, rd_v);
		chk(16'(rd_v), 16'h0000, "force bits readback");
		ctrl(8'h00);
		$display("test registers done");
		for (int c = 1; c <= 5; c++) begin
			w16(0, 16'h0000);
			ctrl(8'(c));
			repeat (divs[c] * 3 - 2) @(posedge clk);
			ctrl(8'h00);
			mdl[0] = 3;
			r16(0);
		end
		$display("test prescaler done");
		// three rising and two falling edges per run
		for (int c = 6; c <= 7; c++) begin
			w16(0, 16'h0000);
			ctrl(8'(c));
			repeat (3) begin
				@(posedge clk) ext_pin <= 1'b0;
				repeat (2) @(posedge clk);
				ext_pin <= 1'b1;
				repeat (2) @(posedge clk);
			end
			ctrl(8'h00);
			@(posedge clk) ext_pin <= 1'b0;
			mdl[0] = (c == 6) ? 2 : 3;
			r16(0);
		end
		$display("test external clock done");
		@(posedge clk) com_a <= tmr_pkg::COM_TOGGLE;
		com_b <= tmr_pkg::COM_SET;
		w16(2, 16'h0005);
		w16(3, 16'h0007);
		w16(0, 16'h0000);
		ctrl(8'h01);
		wait_flag(1, d0);
		wait_flag(2, d1);
		chk(16'(d0), 16'd7, "compare A flag delay");
		chk(16'(d0 + d1), 16'd9, "compare B flag delay");
		chk(16'({oc_a, oc_b, oc_a_en, oc_b_en}), 16'h000F, "compare outputs");
		ctrl(8'h00);
		clr();
		w16(2, 16'h0010);
		ctrl(8'h01);
		w16(0, 16'h0010);
		repeat (20) @(posedge clk);
		#1 chk(16'({f_a, oc_a}), 16'h0001, "blocked match");
		ctrl(8'h00);
		$display("test compare done");
		@(posedge clk) com_b <= tmr_pkg::COM_CLEAR;
		w16(0, 16'h0042);
		for (int m = 0; m < 16; m++) begin
			if (m == 13) continue;
			@(posedge clk) wm_lo <= 2'(m);
			ctrl(8'((m & 12) << 1));
			ov = oc_a;
			i_tmr_cpu_model.wr8(tmr_pkg::OFF_CTRL_C, 8'hC0);
			@(posedge clk);
			#1 chk(16'(oc_a), 16'((m == 0 || m == 4 || m == 12) ? !ov : ov), "forced A");
			chk(16'({oc_b, f_a, f_b}), 16'h0000, "forced B, no flags");
		end
		r16(0);
		@(posedge clk) wm_lo <= 2'h0;
		com_a <= tmr_pkg::COM_SET;
		i_tmr_cpu_model.wr8(tmr_pkg::OFF_CTRL_C, 8'h80);
		@(posedge clk);
		#1 chk(16'(oc_a), 16'h0001, "forced set A");
		$display("test force done");
		cap_step(8'h40, 1'b1, 1'b1, d0);
		chk(16'(d0), 16'd2, "capture delay unfiltered");
		cap_step(8'h40, 1'b0, 1'b0, d1);
		cap_step(8'h00, 1'b1, 1'b0, d1);
		cap_step(8'h00, 1'b0, 1'b1, d1);
		cap_step(8'hC0, 1'b1, 1'b1, d1);
		chk(16'(d1 - d0), 16'd4, "filter delay");
		@(posedge clk) cap_pin <= 1'b0;
		repeat (3) @(posedge clk);
		cap_pin <= 1'b1;
		wait_flag(0, d1);
		chk(16'(f_cap), 16'h0000, "filtered glitch");
		@(posedge clk) src_an <= 1'b1;
		cap_step(8'h40, 1'b1, 1'b1, d1);
		cap_step(8'h58, 1'b0, 1'b0, d1);
		cap_step(8'h58, 1'b1, 1'b0, d1);
		$display("test capture done");
		report_and_stop();
	end
endmodule : tmr_top_tb_top
`default_nettype wire
